// File: rtl/tso_params.svh
`ifndef TSO_PARAMS_SVH
`define TSO_PARAMS_SVH

// ---------------------------------------------------------------
// Entry area and FIFO sizing
// ---------------------------------------------------------------
`define TSO_CHANNELS 2
`define TSO_CAP_SMALL 4'h5
`define TSO_CAP_LARGE 4'hf
`define TSO_FIFO_MAX 5'h1f

// ---------------------------------------------------------------
// Entry field positions
// ---------------------------------------------------------------
`define TSO_EN0_BIT 5
`define TSO_EN1_BIT 4
`define TSO_ST0_BIT 7
`define TSO_ST1_BIT 6
`define TSO_SEQ_END_BIT 6
`define TSO_SEQ_FIRST 6'h01

// ---------------------------------------------------------------
// Status area codes
// ---------------------------------------------------------------
`define TSO_FS_OK 8'h00
`define TSO_FS_MISS 8'h01
`define TSO_FS_NONE 8'h02
`define TSO_FS_FULL 8'h03
`define TSO_FS_MARK 8'h80
`define TSO_LAST_TAG 2'h1
`define TSO_NEXT_TAG 2'h3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TSO_CLK_NS 10
`define TSO_TICK_NS 1000
`define TSO_US_CYCLES ((`TSO_TICK_NS + `TSO_CLK_NS - 1) / `TSO_CLK_NS)

// ---------------------------------------------------------------
// Controller register offsets (APB byte addresses)
// ---------------------------------------------------------------
`define TSO_REG_CTRL 8'h00
`define TSO_REG_IDX 8'h04
`define TSO_REG_DATA 8'h08
`define TSO_REG_STAT 8'h0c
`define TSO_CTRL_CFG_BIT 0
`define TSO_CTRL_COMMIT_BIT 1
`define TSO_CTRL_BUSY_BIT 2

`endif

// File: rtl/tso_pkg.sv
package tso_pkg;

  // Four-byte entry, byte 0 lowest
  typedef struct packed {
    logic [15:0] target_time_value;
    logic [7:0] sequence_number;
    logic [7:0] output_control_byte;
  } tso_entry_s;

  typedef enum logic {TSO_IDLE, TSO_SCAN} tso_phase_e;

  typedef struct packed {
    logic [31:0][31:0] mem;
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [4:0] count;
  } tso_fifo_s;

  typedef struct packed {
    logic [31:0] ticker;
    logic [6:0] presc;
    logic [14:0][31:0] area;
    tso_phase_e phase;
    logic [3:0] idx;
    logic [5:0] expected;
    logic [5:0] last_acc;
    logic [7:0] fstate;
    logic [4:0] mark_cnt;
    logic [1:0] ch_en;
    logic [1:0] ch_state;
    logic [1:0] ch_out;
    logic fault;
  } tso_dev_s;

  typedef struct packed {
    logic cfg_large;
    logic [3:0] idx;
    logic [3:0] widx;
    logic [31:0] data;
    logic we;
    logic commit;
    logic [31:0] prdata;
  } tso_host_s;

endpackage

// File: rtl/tso_if.sv
`timescale 1ns/1ns
// Process image link between controller and output unit
interface tso_if;
  logic img_we;
  logic [3:0] img_idx;
  logic [31:0] img_data;
  logic img_commit;
  logic cfg_large;
  logic [31:0] stat_word;
  logic scan_busy;

  modport device (
    input img_we,
    input img_idx,
    input img_data,
    input img_commit,
    input cfg_large,
    output stat_word,
    output scan_busy
  );

  modport host (
    output img_we,
    output img_idx,
    output img_data,
    output img_commit,
    output cfg_large,
    input stat_word,
    input scan_busy
  );
endinterface

// File: rtl/tso_fifo.sv
`timescale 1ns/1ns
`include "tso_params.svh"
module tso_fifo (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] head,
  output logic [4:0] count,
  output logic full,
  output logic empty
);
  import tso_pkg::*;

  tso_fifo_s st;
  tso_fifo_s next_st;

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  // Thirty-two slots, but count stops at 31 so pointers never alias
  always_comb begin
    next_st = st;
    if (push && !full) begin
      next_st.mem[st.wr_ptr] = push_data;
      next_st.wr_ptr = st.wr_ptr + 5'h1;
    end
    if (pop && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 5'h1;
    end
    next_st.count = st.count + {4'h0, push && !full} - {4'h0, pop && !empty};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.mem[st.rd_ptr];
  assign count = st.count;
  assign full = (st.count == `TSO_FIFO_MAX);
  assign empty = (st.count == 5'h0);
endmodule

// File: rtl/tso_device.sv
`timescale 1ns/1ns
`include "tso_params.svh"
// Functional notes
// - Two outputs change only at scheduled times
// - Entry area holds five or fifteen entries
// - Device FIFO holds at most 31 entries
// - Entries offered to full FIFO are dropped
// - Host checks FIFO state before offering entries
// - Byte 0: last accepted number, tag 01
// - Byte 1: next executed number, tag 11
// - State 00 after store, 03 when full
// - State 01 bad number, 02 nothing new
// - Marked entry in FIFO sets state bit 7
// - Entries after a marked entry are ignored
// - Host marks last entry or invalidates rest
// - Byte 3 gives current FIFO entry count
// - Entry: control, number, two-byte time
// - Control byte: enables bits 5/4, states 7/6
// - Host avoids enable and state together
// - Numbers run 0 to 63, start at 1
// - Only previous number plus one is accepted
// - Free 32-bit microsecond ticker, wrapping
// - Entry time matches ticker low word
// - Fault indicator on overload, short, overheat
module tso_device (
  input wire logic core_clk,
  input wire logic reset_n,
  tso_if.device link,
  input wire logic overload,
  input wire logic short_circuit,
  input wire logic overheat,
  output logic [1:0] chan_out,
  output logic [31:0] us_ticker,
  output logic module_fault_indicator
);
  import tso_pkg::*;

  tso_dev_s st;
  tso_dev_s next_st;
  logic push;
  logic pop;
  logic [31:0] head_word;
  logic [4:0] fifo_count;
  logic fifo_full;
  logic fifo_empty;
  tso_entry_s cur;
  tso_entry_s head;
  logic [3:0] cap;
  logic push_mark;
  logic pop_mark;
  logic due;
  logic [1:0] ctl_en;
  logic [1:0] ctl_state;

  // ---------------------------------------------------------------
  // Entry FIFO
  // ---------------------------------------------------------------
  // The FIFO only stores words; accept and execute rules live here
  tso_fifo u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .push(push),
    .push_data(st.area[st.idx]),
    .pop(pop),
    .head(head_word),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  assign head = head_word;
  assign cur = st.area[st.idx];
  // Capacity is read at every slot, so the host keeps it steady during a scan
  assign cap = link.cfg_large ? `TSO_CAP_LARGE : `TSO_CAP_SMALL;

  // Head entry falls due when the ticker low word meets its time
  assign due = !fifo_empty && (head.target_time_value == st.ticker[15:0]);

  // ---------------------------------------------------------------
  // Per-channel control decode
  // ---------------------------------------------------------------
  // Enable and state bits sit in mirrored order, channel 0 on the upper bit
  for (genvar c = 0; c < `TSO_CHANNELS; c++) begin : g_chan
    assign ctl_en[c] = head.output_control_byte[(c == 0) ? `TSO_EN0_BIT : `TSO_EN1_BIT];
    assign ctl_state[c] = head.output_control_byte[(c == 0) ? `TSO_ST0_BIT : `TSO_ST1_BIT];
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Scan walks the area one entry a cycle; busy stops new commits
  always_comb begin
    next_st = st;
    push = 1'b0;
    pop = 1'b0;
    push_mark = 1'b0;
    pop_mark = 1'b0;

    // Microsecond ticker, wraps by natural overflow
    // One microsecond is a whole number of clocks at the fixed core rate
    if (st.presc == 7'(`TSO_US_CYCLES - 1)) begin
      next_st.presc = 7'h0;
      next_st.ticker = st.ticker + 32'h1;
    end else begin
      next_st.presc = st.presc + 7'h1;
    end

    // Host writes into the entry area, a write to slot index fifteen is dropped
    if (link.img_we && (link.img_idx < `TSO_CAP_LARGE)) begin
      next_st.area[link.img_idx] = link.img_data;
    end

    // Scan: one slot a cycle; a refusal, a marker or the last slot ends it
    unique case (st.phase)
      TSO_IDLE: begin
        if (link.img_commit) begin
          next_st.phase = TSO_SCAN;
          next_st.idx = 4'h0;
        end
      end
      TSO_SCAN: begin
        if (cur.sequence_number[5:0] != st.expected) begin
          // Stale first entry means nothing new was offered
          if (st.idx == 4'h0) begin
            if (cur.sequence_number[5:0] == st.last_acc) begin
              next_st.fstate = `TSO_FS_NONE;
            end else begin
              next_st.fstate = `TSO_FS_MISS;
            end
          end
          // A later mismatch ends the batch and keeps the last code
          next_st.phase = TSO_IDLE;
        end else if (fifo_full) begin
          // Full: the entry is not stored and the batch stops here
          next_st.fstate = `TSO_FS_FULL;
          next_st.phase = TSO_IDLE;
        end else begin
          push = 1'b1;
          push_mark = cur.sequence_number[`TSO_SEQ_END_BIT];
          next_st.last_acc = cur.sequence_number[5:0];
          next_st.expected = cur.sequence_number[5:0] + 6'h1;
          // Report full at once so the host does not lose the next batch;
          // a pop in the same cycle frees the slot again, so it is not full then
          if ((fifo_count == (`TSO_FIFO_MAX - 5'h1)) && !due) begin
            next_st.fstate = `TSO_FS_FULL;
          end else begin
            next_st.fstate = `TSO_FS_OK;
          end
          next_st.idx = st.idx + 4'h1;
          if (push_mark || (st.idx == (cap - 4'h1))) begin
            next_st.phase = TSO_IDLE;
          end
        end
      end
    endcase

    // Execute the head entry once it falls due
    if (due) begin
      pop = 1'b1;
      pop_mark = head.sequence_number[`TSO_SEQ_END_BIT];
      next_st.ch_en = ctl_en;
      next_st.ch_state = ctl_state;
      // Only draining the last entry reports that nothing new is left
      if ((fifo_count == 5'h1) && !push) begin
        next_st.fstate = `TSO_FS_NONE;
      end
    end

    // Marked entries in flight; back to zero once they have all run
    next_st.mark_cnt = st.mark_cnt + {4'h0, push_mark} - {4'h0, pop_mark};

    // Disabled channel is held low whatever its state bit says
    for (int c = 0; c < `TSO_CHANNELS; c++) begin
      next_st.ch_out[c] = next_st.ch_en[c] & next_st.ch_state[c];
    end

    // Fault inputs are synchronous; one flop keeps the indicator glitch free
    next_st.fault = overload | short_circuit | overheat;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset empties the FIFO and restarts the numbering at its first value
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.expected <= `TSO_SEQ_FIRST;
      st.fstate <= `TSO_FS_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Status area and outputs
  // ---------------------------------------------------------------
  // Status bytes come straight from flops, so the host never waits for them
  assign link.stat_word[7:0] = {`TSO_LAST_TAG, st.last_acc};
  // The next-to-run number falls back to the expected one while the FIFO is empty
  assign link.stat_word[15:8] = {`TSO_NEXT_TAG,
                                 fifo_empty ? st.expected : head.sequence_number[5:0]};
  assign link.stat_word[23:16] = st.fstate | ((st.mark_cnt != 5'h0) ? `TSO_FS_MARK : 8'h00);
  assign link.stat_word[31:24] = {3'h0, fifo_count};
  assign link.scan_busy = (st.phase == TSO_SCAN);
  assign chan_out = st.ch_out;
  assign us_ticker = st.ticker;
  assign module_fault_indicator = st.fault;
endmodule

// File: rtl/tso_host.sv
`timescale 1ns/1ns
`include "tso_params.svh"
module tso_host (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tso_if.host link
);
  import tso_pkg::*;

  tso_host_s st;
  tso_host_s next_st;
  logic setup;
  logic access;
  logic mapped;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == `TSO_REG_CTRL) || (paddr == `TSO_REG_IDX) ||
                  (paddr == `TSO_REG_DATA) || (paddr == `TSO_REG_STAT);

  // ---------------------------------------------------------------
  // APB slave and image writer
  // ---------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase is one cycle
  always_comb begin
    next_st = st;
    next_st.we = 1'b0;
    next_st.commit = 1'b0;
    if (setup) begin
      next_st.prdata = 32'h0;
      unique case (paddr)
        `TSO_REG_CTRL: begin
          next_st.prdata[`TSO_CTRL_CFG_BIT] = st.cfg_large;
          next_st.prdata[`TSO_CTRL_BUSY_BIT] = link.scan_busy;
        end
        `TSO_REG_IDX: next_st.prdata[3:0] = st.idx;
        `TSO_REG_STAT: next_st.prdata = link.stat_word;
        default: next_st.prdata = 32'h0;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        `TSO_REG_CTRL: begin
          next_st.cfg_large = pwdata[`TSO_CTRL_CFG_BIT];
          // The device ignores a commit during a scan and never restarts it mid-batch; drop it here too
          next_st.commit = pwdata[`TSO_CTRL_COMMIT_BIT] && !link.scan_busy;
        end
        `TSO_REG_IDX: next_st.idx = pwdata[3:0];
        `TSO_REG_DATA: begin
          next_st.data = pwdata;
          next_st.widx = st.idx;
          next_st.idx = st.idx + 4'h1;
          next_st.we = 1'b1;
        end
        default: next_st.we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign link.img_we = st.we;
  assign link.img_idx = st.widx;
  assign link.img_data = st.data;
  assign link.img_commit = st.commit;
  assign link.cfg_large = st.cfg_large;
endmodule

// File: test/tso_properties.sv
`timescale 1ns/1ns
module tso_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic img_commit,
  input wire logic scan_busy,
  input wire logic [31:0] stat_word
);
  // ----------------------------------------
  // Status area and scan checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // A commit is only honoured while idle
  sequence s_commit;
    img_commit && !scan_busy;
  endsequence
  // Fifteen slots at one a cycle, plus slack for the end test
  sequence s_scan_end;
    scan_busy ##[1:17] !scan_busy;
  endsequence
  a_last_tag_fixed: assert property (stat_word[7:6] == 2'b01)
    else $error("last accepted tag wrong");
  a_next_tag_fixed: assert property (stat_word[15:14] == 2'b11)
    else $error("next executed tag wrong");
  a_state_code_legal: assert property (stat_word[22:18] == 5'h00)
    else $error("fifo state code out of range");
  a_count_ceiling: assert property (stat_word[31:24] <= 8'h1f)
    else $error("fifo count above ceiling");
  a_mark_needs_entry: assert property (stat_word[23] |-> stat_word[31:24] != 8'h00)
    else $error("marked state with empty fifo");
  a_commit_scan: assert property (s_commit |=> s_scan_end)
    else $error("scan did not start or end in time");
  a_no_idle_growth: assert property (!scan_busy && !$past(scan_busy)
    |-> stat_word[31:24] <= $past(stat_word[31:24]))
    else $error("fifo grew outside a scan");
  a_full_code: assert property ($rose(stat_word[31:24] == 8'h1f)
    |-> stat_word[17:16] == 2'h3)
    else $error("full fifo not reported");
  a_drain_none: assert property ($fell(stat_word[31:24] != 8'h00) && !scan_busy
    && !$past(scan_busy) |-> stat_word[23:16] == 8'h02)
    else $error("drained fifo not reported as empty");
endmodule

// File: test/timestamped_output_scheduler_test.sv
`timescale 1ns/1ns
`include "tso_params.svh"
module timestamped_output_scheduler_test;
  import tso_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] flt = 3'h0;
  logic [1:0] chan_out;
  logic [31:0] us_ticker;
  logic fault_led;
  logic [31:0] rd;
  logic er;
  logic [15:0] t;
  logic [7:0] c0;
  logic [7:0] c1;
  int error_cnt = 0;
  int n_checks = 0;
  tso_entry_s ent [15];
  tso_if link();
  tso_host u_tso_host (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  tso_device u_tso_device (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .overload(flt[0]), .short_circuit(flt[1]), .overheat(flt[2]), .chan_out(chan_out),
    .us_ticker(us_ticker), .module_fault_indicator(fault_led));
  tso_properties u_tso_properties (.core_clk(core_clk), .reset_n(reset_n),
    .img_commit(link.img_commit), .scan_busy(link.scan_busy), .stat_word(link.stat_word));
  // ----------------------------------------
  // Clock, watchdog, helpers
  // ----------------------------------------
  initial forever #5 core_clk = ~core_clk;
  // Whole run needs under two thousand cycles; this bound cuts a hang
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  function automatic logic [31:0] exp_stat(input logic [5:0] last, input logic [5:0] nxt,
                                           input logic [7:0] st, input logic [7:0] cnt);
    return {cnt, st, 2'b11, nxt, 2'b01, last};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; the extra edge at the end keeps psel from toggling twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Load n slots, commit, wait out the scan, then read the status word
  task automatic send(input logic big, input int n);
    logic saw;
    apb(1'b1, `TSO_REG_CTRL, {31'h0, big});
    apb(1'b1, `TSO_REG_IDX, 32'h0);
    for (int i = 0; i < n; i++) apb(1'b1, `TSO_REG_DATA, ent[i]);
    apb(1'b1, `TSO_REG_CTRL, {30'h0, 1'b1, big});
    saw = 1'b0;
    for (int i = 0; i < 12 && !saw; i++) begin
      saw = link.scan_busy;
      if (!saw) @(posedge core_clk);
    end
    while (link.scan_busy) @(posedge core_clk);
    chk({31'h0, saw}, 32'h1);
    apb(1'b0, `TSO_REG_STAT, 32'h0);
  endtask
  task automatic fill(input logic [5:0] s0, input logic [15:0] tm);
    for (int i = 0; i < 15; i++) ent[i] = {tm, 2'b00, s0 + 6'(i), 4'($urandom), 4'h0};
  endtask
  task automatic wait_us(input logic [15:0] v);
    while (us_ticker[15:0] !== v) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd3e33701));
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `TSO_REG_STAT, 32'h0);
    chk(rd, exp_stat(6'h00, 6'h01, 8'h02, 8'h00));
    apb(1'b0, `TSO_REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `TSO_REG_IDX, 32'h5);
    apb(1'b0, `TSO_REG_IDX, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, `TSO_REG_DATA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 32'hffffffff);
    chk({rd[30:0], er}, 32'h1);
    $display("test reset done");
    // Enable first with states low, then change states, then drop channel 1;
    // the marked third entry ends the batch and the fourth slot is ignored
    t = us_ticker[15:0] + 16'h8;
    c1 = {2'($urandom), 2'b11, 4'h0};
    c0 = {c1[7:6], 2'b10, 4'h0};
    ent[0] = {t, 8'h01, 8'h30};
    ent[1] = {t + 16'h2, 8'h02, c1};
    ent[2] = {t + 16'h4, 8'h43, c0};
    ent[3] = {t + 16'h1, 8'h04, 8'hf0};
    send(1'b0, 4);
    chk(rd, exp_stat(6'h03, 6'h01, 8'h80, 8'h03));
    wait_us(t - 16'h1);
    chk(chan_out, 2'b00);
    wait_us(t + 16'h1);
    chk(chan_out, 2'b00);
    wait_us(t + 16'h3);
    chk(chan_out, {c1[6], c1[7]});
    wait_us(t + 16'h5);
    chk(chan_out, {1'b0, c1[7]});
    apb(1'b0, `TSO_REG_STAT, 32'h0);
    chk(rd, exp_stat(6'h03, 6'h04, 8'h02, 8'h00));
    $display("test schedule done");
    // Repeated number means nothing new; a skipped number is a gap
    for (int i = 0; i < 2; i++) begin
      ent[0] = {t, (i == 0) ? 8'h03 : 8'h09, 8'h30};
      send(1'b0, 1);
      chk(rd, exp_stat(6'h03, 6'h04, (i == 0) ? 8'h02 : 8'h01, 8'h00));
    end
    $display("test numbering done");
    // Far-future times keep entries queued until the fifo fills
    fill(6'h04, us_ticker[15:0] - 16'h1);
    send(1'b0, 15);
    chk(rd, exp_stat(6'h08, 6'h04, 8'h00, 8'h05));
    fill(6'h09, us_ticker[15:0] - 16'h1);
    send(1'b1, 15);
    chk(rd, exp_stat(6'h17, 6'h04, 8'h00, 8'h14));
    fill(6'h18, us_ticker[15:0] - 16'h1);
    send(1'b1, 15);
    chk(rd, exp_stat(6'h22, 6'h04, 8'h03, 8'h1f));
    $display("test fill done");
    for (int i = 0; i < 16; i++) begin
      flt <= 3'($urandom);
      @(posedge core_clk);
      @(posedge core_clk);
      chk({31'h0, fault_led}, {31'h0, |flt});
    end
    $display("test fault done");
    test_done();
  end
endmodule
